// ### src/interrupt_control_status_consts.svh
// Constants for the interrupt control/status upper-half block.
// Assumes inclusion by its bare name from the design file and the testbench.
`ifndef IRQ_CSR_CONSTS_SVH
`define IRQ_CSR_CONSTS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ICS_OFFSET_HOST   8'h68
`define ICS_OFFSET_LOCAL  8'he8
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ICS_HOST_EN       8
`define ICS_HDB_EN        9
`define ICS_ABT_EN        10
`define ICS_LIN_EN        11
`define ICS_RTRY_EN       12
`define ICS_HDB_ACT       13
`define ICS_ABT_ACT       14
`define ICS_LIN_ACT       15
`define ICS_LOUT_EN       16
`define ICS_LDB_EN        17
`define ICS_DMA0_EN       18
`define ICS_DMA1_EN       19
`define ICS_LDB_ACT       20
`define ICS_DMA0_ACT      21
`define ICS_DMA1_ACT      22
`define ICS_BIST_ACT      23
`define ICS_DM_MST_N      24
`define ICS_D0_MST_N      25
`define ICS_D1_MST_N      26
`define ICS_RTRY_ABT_N    27
`define ICS_MBOX_LO       28
`define ICS_MBOX_IN_EN    3
// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define ICS_CTRL_RESET    8'h01
`define ICS_LCTRL_RESET   4'h1
`define ICS_MST_RESET     4'hf
`define ICS_RDATA_RESET   32'h0f01_0100
`define ICS_RETRY_LIMIT   256
`endif

// ### src/interrupt_control_status_ctrl.sv
// Upper half (bits 31:8) of the bridge interrupt control/status register.
// Assumes sources and clears arrive synchronous to clk except local_irq_in_n.
`timescale 1ns/100ps
`include "interrupt_control_status_consts.svh"
module irq_csr_ctrl (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // Register access, one port per side
   input  wire logic                 host_wr,
   input  wire logic                 local_wr,
   input  wire logic [31:0]          host_wdata,
   input  wire logic [31:0]          local_wdata,
   output logic      [31:0]          csr_rdata,
   // Mailbox enable and mailbox events
   input  wire logic                 mbox_irq_en,
   input  wire logic [3:0]           mbox_host_wr,
   input  wire logic [3:0]           mbox_local_rd,
   // Interrupt sources
   input  wire logic                 local_to_host_doorbell_any,
   input  wire logic                 host_to_local_doorbell_any,
   input  wire logic [1:0]           pci_status_abort,
   input  wire logic                 local_irq_in_n,
   input  wire logic                 dma_ch0_done,
   input  wire logic                 dma_ch1_done,
   input  wire logic                 dma_ch0_mode_route,
   input  wire logic                 dma_ch1_mode_route,
   input  wire logic                 dma_ch0_clr,
   input  wire logic                 dma_ch1_clr,
   input  wire logic                 self_test_irq_en,
   input  wire logic                 self_test_done,
   // Master activity
   input  wire logic                 abort_event,
   input  wire irq_csr_pkg::master_type abort_master,
   input  wire logic                 retry_seen,
   input  wire logic                 xfer_done,
   // Outputs
   output logic                      inta_n,
   output logic                      local_irq_out_n,
   output logic                      retry_target_abort
);
   import irq_csr_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  lin_sync;
      logic [4:0]  ctrl;      // Bits 12:8
      logic [3:0]  lctrl;     // Bits 19:16
      logic        dma0_act;
      logic        dma1_act;
      logic        bist_act;
      logic [3:0]  mst_n;     // Bits 27:24
      logic [3:0]  mbox;
      logic [8:0]  retry_cnt;
      logic        rtry_abt;
      logic        inta_n;
      logic        lout_n;
      logic [31:0] rdata;
   } state_type;

   state_type s_reg;
   state_type s_next;
   logic [1:0] rst_sync_reg;
   logic      rst_int_b;
   logic      hdb_act, abt_act, lin_act, ldb_act;
   logic      host_irq, local_irq;

   assign rst_int_b = rst_sync_reg[1];

   // Reset release sync kept out of the struct: it resets the struct itself
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.lin_sync = {s_reg.lin_sync[0], ~local_irq_in_n};
      // Same-cycle writes: local port wins, both write only control bits
      if (host_wr) begin
         s_next.ctrl  = host_wdata[12:8];
         s_next.lctrl = host_wdata[19:16];
      end
      if (local_wr) begin
         s_next.ctrl  = local_wdata[12:8];
         s_next.lctrl = local_wdata[19:16];
      end
      // Sticky DMA events, set beats clear
      if (dma_ch0_clr) s_next.dma0_act = 1'b0;
      if (dma_ch0_done) s_next.dma0_act = 1'b1;
      if (dma_ch1_clr) s_next.dma1_act = 1'b0;
      if (dma_ch1_done) s_next.dma1_act = 1'b1;
      // Self-test event, dropped when its enable falls
      if (self_test_done && self_test_irq_en) s_next.bist_act = 1'b1;
      else if (!self_test_irq_en) s_next.bist_act = 1'b0;
      // Mailbox flags: write sets, local read clears
      for (int i = 0; i < 4; i++) begin
         if (mbox_local_rd[i]) s_next.mbox[i] = 1'b0;
         if (mbox_host_wr[i] && mbox_irq_en) s_next.mbox[i] = 1'b1;
      end
      // Retry counting; limit only applies with bit 12 set
      s_next.rtry_abt = 1'b0;
      if (xfer_done || abort_event) begin
         s_next.retry_cnt = 9'h000;
      end else if (retry_seen && s_reg.ctrl[4]) begin
         if (s_reg.retry_cnt == 9'(`ICS_RETRY_LIMIT - 1)) begin
            s_next.rtry_abt  = 1'b1;
            s_next.retry_cnt = 9'h000;
            s_next.mst_n[3]  = 1'b0;
         end else begin
            s_next.retry_cnt = s_reg.retry_cnt + 9'h001;
         end
      end
      // Record which master saw the abort
      if (abort_event || s_next.rtry_abt) begin
         unique case (abort_master)
            MST_DM:   s_next.mst_n[0] = 1'b0;
            MST_DMA0: s_next.mst_n[1] = 1'b0;
            MST_DMA1: s_next.mst_n[2] = 1'b0;
            MST_NONE: s_next.mst_n[0] = s_reg.mst_n[0];
         endcase
      end
      s_next.inta_n = ~host_irq;
      s_next.lout_n = ~local_irq;
      s_next.rdata  = {s_reg.mbox, s_reg.mst_n, s_reg.bist_act, s_reg.dma1_act,
                       s_reg.dma0_act, ldb_act, s_reg.lctrl, lin_act, abt_act,
                       hdb_act, s_reg.ctrl, 8'h00};
   end

   // ------------------------------------------------------------
   // Interrupt combining
   // ------------------------------------------------------------
   assign hdb_act = s_reg.ctrl[1] & local_to_host_doorbell_any;
   assign abt_act = s_reg.ctrl[2] & (|pci_status_abort);
   assign lin_act = s_reg.ctrl[3] & s_reg.lin_sync[1];
   assign ldb_act = s_reg.lctrl[1] & host_to_local_doorbell_any;
   assign host_irq = s_reg.ctrl[0] & (hdb_act | abt_act | lin_act
                   | (s_reg.lctrl[2] & s_reg.dma0_act & dma_ch0_mode_route)
                   | (s_reg.lctrl[3] & s_reg.dma1_act & dma_ch1_mode_route));
   assign local_irq = s_reg.lctrl[0] & (ldb_act | (|s_reg.mbox)
                    | s_reg.bist_act
                    | (s_reg.lctrl[2] & s_reg.dma0_act & ~dma_ch0_mode_route)
                    | (s_reg.lctrl[3] & s_reg.dma1_act & ~dma_ch1_mode_route));

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         s_reg.lin_sync  <= 2'h0;
         s_reg.ctrl      <= 5'(`ICS_CTRL_RESET);
         s_reg.lctrl     <= `ICS_LCTRL_RESET;
         s_reg.dma0_act  <= 1'b0;
         s_reg.dma1_act  <= 1'b0;
         s_reg.bist_act  <= 1'b0;
         s_reg.mst_n     <= `ICS_MST_RESET;
         s_reg.mbox      <= 4'h0;
         s_reg.retry_cnt <= 9'h000;
         s_reg.rtry_abt  <= 1'b0;
         s_reg.inta_n    <= 1'b1;
         s_reg.lout_n    <= 1'b1;
         s_reg.rdata     <= `ICS_RDATA_RESET;
      end else begin
         s_reg.lin_sync  <= s_next.lin_sync;
         s_reg.ctrl      <= s_next.ctrl;
         s_reg.lctrl     <= s_next.lctrl;
         s_reg.dma0_act  <= s_next.dma0_act;
         s_reg.dma1_act  <= s_next.dma1_act;
         s_reg.bist_act  <= s_next.bist_act;
         s_reg.mst_n     <= s_next.mst_n;
         s_reg.mbox      <= s_next.mbox;
         s_reg.retry_cnt <= s_next.retry_cnt;
         s_reg.rtry_abt  <= s_next.rtry_abt;
         s_reg.inta_n    <= s_next.inta_n;
         s_reg.lout_n    <= s_next.lout_n;
         s_reg.rdata     <= s_next.rdata;
      end
   end

   assign csr_rdata          = s_reg.rdata;
   assign inta_n             = s_reg.inta_n;
   assign local_irq_out_n    = s_reg.lout_n;
   assign retry_target_abort = s_reg.rtry_abt;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_host_gate: assert property (@(posedge clk) disable iff (!rst_int_b)
      !s_reg.ctrl[0] |=> inta_n) else $error("host line active while disabled");
   chk_local_gate: assert property (@(posedge clk) disable iff (!rst_int_b)
      !s_reg.lctrl[0] |=> local_irq_out_n) else $error("local line active while disabled");
   chk_doorbell_host: assert property (@(posedge clk) disable iff (!rst_int_b)
      (s_reg.ctrl[0] && s_reg.ctrl[1] && local_to_host_doorbell_any) |=> !inta_n)
      else $error("doorbell did not raise host line");
   chk_mbox_local: assert property (@(posedge clk) disable iff (!rst_int_b)
      (|s_reg.mbox && s_reg.lctrl[0]) |=> !local_irq_out_n)
      else $error("mailbox flag did not raise local line");
   chk_mbox_gate: assert property (@(posedge clk) disable iff (!rst_int_b)
      (!mbox_irq_en && s_reg.mbox == 4'h0) |=> s_reg.mbox == 4'h0)
      else $error("mailbox flag set while disabled");
   chk_retry_limit: assert property (@(posedge clk) disable iff (!rst_int_b)
      retry_target_abort |-> !s_reg.mst_n[3] && $past(s_reg.retry_cnt) == 9'd255)
      else $error("retry abort at wrong count");
   chk_retry_off: assert property (@(posedge clk) disable iff (!rst_int_b)
      !s_reg.ctrl[4] |=> !retry_target_abort) else $error("retry abort while disabled");
   chk_dma_clear: assert property (@(posedge clk) disable iff (!rst_int_b)
      (dma_ch0_clr && !dma_ch0_done) |=> ##1 !csr_rdata[`ICS_DMA0_ACT])
      else $error("dma channel 0 flag not cleared");
   chk_ro_write: assert property (@(posedge clk) disable iff (!rst_int_b)
      ((host_wr || local_wr) && !abort_event && !retry_seen
       && mbox_host_wr == 4'h0 && mbox_local_rd == 4'h0)
      |=> $stable(s_reg.mst_n) && $stable(s_reg.mbox)) else $error("write hit status");
   cov_host_irq: cover property (@(posedge clk) disable iff (!rst_int_b) $fell(inta_n));
   cov_local_irq: cover property (@(posedge clk) disable iff (!rst_int_b)
      $fell(local_irq_out_n));
   cov_retry_abt: cover property (@(posedge clk) disable iff (!rst_int_b) retry_target_abort);
endmodule : irq_csr_ctrl

// ### src/interrupt_control_status_pkg.sv
// Types for the interrupt control/status block.
// Assumes the constants header sits on the include path.
package irq_csr_pkg;
   typedef enum logic [1:0] {
      MST_NONE = 2'h0,
      MST_DM   = 2'h1,
      MST_DMA0 = 2'h3,
      MST_DMA1 = 2'h2
   } master_type;
endpackage : irq_csr_pkg

// ### tb/bridge_sw_model.sv
// Software on both sides of the bridge: doorbell registers and mailbox reads.
// Assumes the bench drives one-cycle action pulses just after a falling edge.
`timescale 1ns/100ps
module bridge_sw_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Software actions
   input  wire logic       ring_l2h,
   input  wire logic       ring_h2l,
   input  wire logic       wipe_l2h,
   input  wire logic       wipe_h2l,
   input  wire logic [3:0] mbox_read,
   // Toward the block
   output logic            l2h_any,
   output logic            h2l_any,
   output logic [3:0]      mbox_local_rd
);
   // ----------------------------------------
   // Doorbells
   // ----------------------------------------
   logic [1:0] bell_reg;
   // Set by the ringing side, cleared by the other; clear wins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) bell_reg <= 2'h0;
      else bell_reg <= (bell_reg | {ring_h2l, ring_l2h})
                       & ~{wipe_h2l, wipe_l2h};
   end
   assign l2h_any = bell_reg[0];
   assign h2l_any = bell_reg[1];
   // Local master reading a mailbox is what clears its flag
   assign mbox_local_rd = mbox_read;
endmodule : bridge_sw_model

// ### tb/tb_pci_bridge_interrupt_control_status.sv
// Self-checking bench for the interrupt control/status upper half.
// Assumes the constants header on the include path; inputs move on falling edges.
`timescale 1ns/100ps
`include "interrupt_control_status_consts.svh"
module tb_pci_bridge_interrupt_control_status;
   import irq_csr_pkg::*;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk = 0, rst_b = 0, host_wr = 0, local_wr = 0, mbox_irq_en = 0, abort_event = 0;
   logic ring_l2h = 0, ring_h2l = 0, wipe_l2h = 0, wipe_h2l = 0, local_irq_in_n = 1;
   logic dma0_done = 0, dma1_done = 0, dma0_route = 0, dma1_route = 0, dma0_clr = 0;
   logic dma1_clr = 0, st_en = 0, st_done = 0, retry_seen = 0, xfer_done = 0;
   logic [31:0] host_wdata = 0, local_wdata = 0, csr_rdata;
   logic [3:0]  mbox_host_wr = 0, mbox_read = 0, mbox_local_rd;
   logic [1:0]  pci_status_abort = 0;
   logic        l2h_any, h2l_any, inta_n, local_irq_out_n, rta;
   master_type  abort_master = MST_NONE;
   int          num_errors = 0, cmp_count = 0, rta_cnt = 0;

   initial forever #12.5 clk = ~clk;
   always @(posedge clk) if (rta === 1'b1) rta_cnt++;

   bridge_sw_model sw (.clk(clk), .rst_b(rst_b), .ring_l2h(ring_l2h), .ring_h2l(ring_h2l),
      .wipe_l2h(wipe_l2h), .wipe_h2l(wipe_h2l), .mbox_read(mbox_read), .l2h_any(l2h_any),
      .h2l_any(h2l_any), .mbox_local_rd(mbox_local_rd));
   irq_csr_ctrl dut (.clk(clk), .rst_b(rst_b), .host_wr(host_wr), .local_wr(local_wr),
      .host_wdata(host_wdata), .local_wdata(local_wdata), .csr_rdata(csr_rdata),
      .mbox_irq_en(mbox_irq_en), .mbox_host_wr(mbox_host_wr), .mbox_local_rd(mbox_local_rd),
      .local_to_host_doorbell_any(l2h_any), .host_to_local_doorbell_any(h2l_any),
      .pci_status_abort(pci_status_abort), .local_irq_in_n(local_irq_in_n),
      .dma_ch0_done(dma0_done), .dma_ch1_done(dma1_done), .dma_ch0_mode_route(dma0_route),
      .dma_ch1_mode_route(dma1_route), .dma_ch0_clr(dma0_clr), .dma_ch1_clr(dma1_clr),
      .self_test_irq_en(st_en), .self_test_done(st_done), .abort_event(abort_event),
      .abort_master(abort_master), .retry_seen(retry_seen), .xfer_done(xfer_done),
      .inta_n(inta_n), .local_irq_out_n(local_irq_out_n), .retry_target_abort(rta));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic wr(input logic [31:0] v, input logic loc);
      if (loc) begin
         local_wdata = v;
         pulse(local_wr);
      end else begin
         host_wdata = v;
         pulse(host_wr);
      end
   endtask : wr
   // Longest path is the synced local input plus the read view lag
   task automatic settle;
      repeat (8) @(negedge clk);
   endtask : settle
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Single-bit compare, padded on purpose to the word compare
   task automatic chk1(input string nm, input logic exp, input logic got);
      chk(nm, {31'h0, exp}, {31'h0, got});
   endtask : chk1
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      chk("reset view", 32'h0f010100, csr_rdata);
      wr(32'hffffffff, 1'b0);
      settle;
      chk("read-only bits", 32'h0f0f1f00, csr_rdata);
      // Host sources: doorbell, abort, local input; each with bit 8 off then on
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 2; m++) begin
            wr(32'h10000 | (m << 8) | (32'h200 << k), k[0]);
            if (k == 0) pulse(ring_l2h);
            pci_status_abort = (k == 1) ? 2'h2 : 2'h0;
            local_irq_in_n = (k != 2);
            settle;
            chk1("host line on", ~m[0], inta_n);
            if (m) chk("host active", 32'h1, {31'h0, csr_rdata[`ICS_HDB_ACT + k]});
            if (k == 0) pulse(wipe_l2h);
            pci_status_abort = 2'h0;
            local_irq_in_n = 1'b1;
            settle;
            chk("host line off", 32'h1, {31'h0, inta_n});
         end
      end
      // Local sources: doorbell, DMA 0, self-test; each with bit 16 off then on
      for (int k = 0; k < 3; k++) begin
         for (int m = 0; m < 2; m++) begin
            wr((m << 16) | (32'h20000 << k), 1'b1);
            if (k == 0) pulse(ring_h2l);
            if (k == 1) pulse(dma0_done);
            st_en = (k == 2);
            if (k == 2) pulse(st_done);
            settle;
            chk1("local line on", ~m[0], local_irq_out_n);
            if (m) chk1("local active", 1'b1, csr_rdata[k[1] ? 23 : 20 + k]);
            if (k == 0) pulse(wipe_h2l);
            if (k == 1) pulse(dma0_clr);
            st_en = 1'b0;
            settle;
            chk("local line off", 32'h1, {31'h0, local_irq_out_n});
         end
      end
      // Both DMA channels routed to the host line
      dma0_route = 1'b1;
      dma1_route = 1'b1;
      for (int c = 0; c < 2; c++) begin
         wr(32'h00000100 | (32'h40000 << c), 1'b0);
         if (c) pulse(dma1_done);
         else pulse(dma0_done);
         settle;
         chk1("dma active", 1'b1, csr_rdata[21 + c]);
         chk1("dma host", 1'b0, inta_n);
         if (c) pulse(dma1_clr);
         else pulse(dma0_clr);
         settle;
         chk1("dma clear", 1'b1, inta_n);
      end
      // Mailbox flags: refused while disabled, then set and read away
      wr(32'h10000, 1'b1);
      for (int i = 0; i < 4; i++) begin
         for (int e = 0; e < 2; e++) begin
            mbox_irq_en = e[0];
            mbox_host_wr = 4'h1 << i;
            @(negedge clk);
            mbox_host_wr = 4'h0;
            settle;
            chk("mailbox flag", e, {31'h0, csr_rdata[`ICS_MBOX_LO + i]});
            chk("mailbox line", {31'h0, ~e[0]}, {31'h0, local_irq_out_n});
            mbox_read = 4'h1 << i;
            @(negedge clk);
            mbox_read = 4'h0;
            settle;
            chk("mailbox read", 32'h0, {31'h0, csr_rdata[`ICS_MBOX_LO + i]});
         end
      end
      // Retry limit: unlimited when off, 256th retry aborts when on
      abort_master = MST_DMA1;
      retry_seen = 1'b1;
      repeat (300) @(negedge clk);
      retry_seen = 1'b0;
      pulse(xfer_done);
      wr(32'h1000, 1'b0);
      retry_seen = 1'b1;
      repeat (255) @(negedge clk);
      retry_seen = 1'b0;
      settle;
      chk("no early abort", 32'h0, rta_cnt);
      pulse(retry_seen);
      settle;
      chk("retry abort", 32'h1, rta_cnt);
      chk("retry flags", 32'h0, {30'h0, csr_rdata[27:26]});
      // Abort master record for the other two masters
      for (int j = 0; j < 2; j++) begin
         abort_master = j ? MST_DMA0 : MST_DM;
         pulse(abort_event);
         settle;
         chk("abort master", 32'h0, {31'h0, csr_rdata[`ICS_DM_MST_N + j]});
      end
      tally_and_finish;
   end

   // Whole run is about a thousand cycles
   initial begin
      #300000;
      num_errors++;
      tally_and_finish;
   end
endmodule : tb_pci_bridge_interrupt_control_status
